// ===== common/timer_pkg.sv
// Shared addresses, field positions and reset values for the timer/counter block
package timer_pkg;
  localparam logic [7:0] ADDR_TIMER_CONTROL        = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE_SELECT    = 8'h89;
  localparam logic [7:0] ADDR_TIMER_ZERO_LOW_BYTE  = 8'h8a;
  localparam logic [7:0] ADDR_TIMER_ONE_LOW_BYTE   = 8'h8b;
  localparam logic [7:0] ADDR_TIMER_ZERO_HIGH_BYTE = 8'h8c;
  localparam logic [7:0] ADDR_TIMER_ONE_HIGH_BYTE  = 8'h8d;
  localparam logic [7:0] ADDR_TIMER_TWO_CONTROL    = 8'hc8;
  localparam logic [7:0] ADDR_TIMER_TWO_RELOAD_LOW = 8'hca;
  localparam logic [7:0] ADDR_TIMER_TWO_RELOAD_HIGH = 8'hcb;
  localparam logic [7:0] ADDR_TIMER_TWO_LOW_BYTE   = 8'hcc;
  localparam logic [7:0] ADDR_TIMER_TWO_HIGH_BYTE  = 8'hcd;
  // Control register bits
  localparam int ONE_FLAG_BIT  = 7;
  localparam int ONE_RUN_BIT   = 6;
  localparam int ZERO_FLAG_BIT = 5;
  localparam int ZERO_RUN_BIT  = 4;
  // Mode register fields
  localparam int ONE_GATE_BIT  = 7;
  localparam int ONE_CSEL_BIT  = 6;
  localparam int ONE_MODE_LSB  = 4;
  localparam int ZERO_GATE_BIT = 3;
  localparam int ZERO_CSEL_BIT = 2;
  localparam int ZERO_MODE_LSB = 0;
  // Timer two control bits
  localparam int TWO_FLAG_BIT  = 7;
  localparam int TWO_RUN_BIT   = 2;
  localparam int TWO_CSEL_BIT  = 1;
  // Mode encodings
  localparam logic [1:0] MODE_PRESCALE = 2'h0;
  localparam logic [1:0] MODE_CASCADE  = 2'h1;
  localparam logic [1:0] MODE_RELOAD   = 2'h2;
  localparam logic [1:0] MODE_SPLIT    = 2'h3;
  localparam logic [4:0] PRESCALE_TOP  = 5'h1f;
  localparam logic [7:0] REG_RESET     = 8'h00;
  // Synchronised pin lanes
  localparam int NUM_PINS  = 5;
  localparam int PIN_CNT0  = 0;
  localparam int PIN_CNT1  = 1;
  localparam int PIN_CNT2  = 2;
  localparam int PIN_IRQ0  = 3;
  localparam int PIN_IRQ1  = 4;
endpackage : timer_pkg

// ===== common/pin_sync_if.sv
// Carrier between the pin synchroniser and the timer core
`timescale 1ns/1ns
interface pin_sync_if;
  logic [timer_pkg::NUM_PINS-1:0] raw;
  logic [timer_pkg::NUM_PINS-1:0] level;
  logic [timer_pkg::NUM_PINS-1:0] fall;
  modport sync (input raw, output level, output fall);
  modport user (output raw, input level, input fall);
endinterface : pin_sync_if

// ===== rtl/count_pin_sync.sv
// Three-stage pin synchroniser with agreed level and falling-edge pulse
`timescale 1ns/1ns
module count_pin_sync (
  input  wire logic clk,
  input  wire logic arst_n,
  pin_sync_if.sync  pins
);
  logic [timer_pkg::NUM_PINS-1:0] s1_q;
  logic [timer_pkg::NUM_PINS-1:0] s2_q;
  logic [timer_pkg::NUM_PINS-1:0] s3_q;
  logic [timer_pkg::NUM_PINS-1:0] level_q;
  logic [timer_pkg::NUM_PINS-1:0] fall_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pins.raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Level moves only when two successive samples agree; a high then low level is one edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      level_q <= '0;
      fall_q  <= '0;
    end else begin
      level_q <= (s2_q & s3_q) | (level_q & (s2_q | s3_q)); // RULE4
      fall_q  <= level_q & ~s2_q & ~s3_q; // RULE3
    end
  end

  assign pins.level = level_q;
  assign pins.fall  = fall_q;
endmodule : count_pin_sync

// ===== rtl/timer_counters.sv
// Three 16-bit timer/counters with their special function registers
//
// How it works
// RULE1 - Three timer/counters, each a high and a low byte, each a timer or an event counter.
// RULE2 - As a timer the low byte advances once per core clock.
// RULE3 - As a counter a high sample followed by a low sample of the count pin advances it.
// RULE4 - Edge recognition needs two cycles, so events count at most at half the clock rate.
// RULE5 - The outside source holds each count pin level for at least one full clock; the synchroniser here needs two agreeing samples of each level.
// RULE6 - With gating set a timer runs only while its irq pin is high and its run bit is set.
// RULE7 - Counter select set counts the pin, clear counts the clock; bit 6 for timer one, bit 2 for zero.
// RULE8 - Mode 00 makes the high byte a counter behind a 5-bit prescaler in the low byte; it is the reset mode.
// RULE9 - Mode 01 cascades both bytes into one 16-bit counter.
// RULE10 - Mode 10 counts the low byte and reloads it from the high byte on each overflow.
// RULE11 - Mode 11 stops timer one.
// RULE12 - Mode 11 on timer zero splits it: low byte on timer zero controls, high byte a timer on timer one controls.
// RULE13 - Mode fields sit in bits 5:4 and 1:0; gating and counter select reset to zero.
// RULE14 - The two control registers are bit addressable, all others byte only.
// RULE15 - A run bit starts its timer when set and stops it when clear.
// RULE16 - Overflow sets the flag, and vectoring to the service routine clears it; timer two has no vector clear, only software clears its flag.
// RULE17 - Overflow is the wrap to zero of the register that tops the selected mode.
`timescale 1ns/1ns
module timer_counters (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  input  wire logic       bit_wr,
  input  wire logic [7:0] bit_addr,
  input  wire logic       bit_wdata,
  input  wire logic       vector_ack_zero,
  input  wire logic       vector_ack_one,
  input  wire logic       count_input_pin_zero,
  input  wire logic       count_input_pin_one,
  input  wire logic       count_input_pin_two,
  input  wire logic       external_irq_pin_zero,
  input  wire logic       external_irq_pin_one,
  output logic            timer_zero_overflow_flag,
  output logic            timer_one_overflow_flag,
  output logic            timer_two_overflow_flag
);
  logic [7:0]  timer_control_q;
  logic [7:0]  timer_mode_select_q;
  logic [7:0]  timer_zero_low_byte_q;
  logic [7:0]  timer_zero_high_byte_q;
  logic [7:0]  timer_one_low_byte_q;
  logic [7:0]  timer_one_high_byte_q;
  logic [7:0]  timer_two_control_q;
  logic [7:0]  timer_two_reload_low_q;
  logic [7:0]  timer_two_reload_high_q;
  logic [7:0]  timer_two_low_byte_q;
  logic [7:0]  timer_two_high_byte_q;
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;
  logic [1:0]  mode0;
  logic [1:0]  mode1;
  logic        split0;
  logic        en0;
  logic        en1;
  logic        tick0;
  logic        tick1;
  logic        tick2;
  logic        tick_split_hi;
  logic        ovf0;
  logic        ovf1;
  logic        ovf2;
  logic [16:0] nxt0;
  logic [16:0] nxt1;
  logic [16:0] nxt2;
  logic        wr_tl0;
  logic        wr_th0;
  logic        wr_tl1;
  logic        wr_th1;
  logic        wr_tl2;
  logic        wr_th2;
  logic        wr_ctrl;
  logic        wr_ctrl2;
  logic        bit_ctrl;
  logic        bit_ctrl2;

  pin_sync_if pins ();

  assign pins.raw[timer_pkg::PIN_CNT0] = count_input_pin_zero;
  assign pins.raw[timer_pkg::PIN_CNT1] = count_input_pin_one;
  assign pins.raw[timer_pkg::PIN_CNT2] = count_input_pin_two;
  assign pins.raw[timer_pkg::PIN_IRQ0] = external_irq_pin_zero;
  assign pins.raw[timer_pkg::PIN_IRQ1] = external_irq_pin_one;

  count_pin_sync count_pin_sync_i (
    .clk    (clk),
    .arst_n (arst_n),
    .pins   (pins)
  );

  // One counting step of a timer in modes 00, 01 and 10; bit 16 is the overflow
  function automatic logic [16:0] count_step(input logic [1:0] md, input logic [7:0] hi, input logic [7:0] lo);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    case (md)
      timer_pkg::MODE_PRESCALE: begin
        if (lo[4:0] == timer_pkg::PRESCALE_TOP) begin // RULE8
          r[16:8] = {1'b0, hi} + 9'h001; // RULE17
          r[4:0]  = 5'h00;
        end else begin
          r[4:0] = lo[4:0] + 5'h01;
        end
      end
      timer_pkg::MODE_CASCADE: r = {1'b0, hi, lo} + 17'h00001; // RULE9
      timer_pkg::MODE_RELOAD: begin
        if (lo == 8'hff) begin // RULE10
          r[7:0] = hi;
          r[16]  = 1'b1;
        end else begin
          r[7:0] = lo + 8'h01;
        end
      end
      default: r = {1'b0, hi, lo};
    endcase
    return r;
  endfunction : count_step

  // Byte and bit address decode; only the two control registers take bit writes
  assign wr_ctrl   = sfr_wr && sfr_addr == timer_pkg::ADDR_TIMER_CONTROL;
  assign wr_ctrl2  = sfr_wr && sfr_addr == timer_pkg::ADDR_TIMER_TWO_CONTROL;
  assign wr_tl0    = sfr_wr && sfr_addr == timer_pkg::ADDR_TIMER_ZERO_LOW_BYTE;
  assign wr_th0    = sfr_wr && sfr_addr == timer_pkg::ADDR_TIMER_ZERO_HIGH_BYTE;
  assign wr_tl1    = sfr_wr && sfr_addr == timer_pkg::ADDR_TIMER_ONE_LOW_BYTE;
  assign wr_th1    = sfr_wr && sfr_addr == timer_pkg::ADDR_TIMER_ONE_HIGH_BYTE;
  assign wr_tl2    = sfr_wr && sfr_addr == timer_pkg::ADDR_TIMER_TWO_LOW_BYTE;
  assign wr_th2    = sfr_wr && sfr_addr == timer_pkg::ADDR_TIMER_TWO_HIGH_BYTE;
  assign bit_ctrl  = bit_wr && bit_addr[7:3] == timer_pkg::ADDR_TIMER_CONTROL[7:3]; // RULE14
  assign bit_ctrl2 = bit_wr && bit_addr[7:3] == timer_pkg::ADDR_TIMER_TWO_CONTROL[7:3]; // RULE14

  assign mode0  = timer_mode_select_q[timer_pkg::ZERO_MODE_LSB +: 2]; // RULE13
  assign mode1  = timer_mode_select_q[timer_pkg::ONE_MODE_LSB +: 2]; // RULE13
  assign split0 = mode0 == timer_pkg::MODE_SPLIT;

  // Run bit, optionally gated by the synchronised irq pin level
  assign en0 = timer_control_q[timer_pkg::ZERO_RUN_BIT] && // RULE15
               (!timer_mode_select_q[timer_pkg::ZERO_GATE_BIT] || pins.level[timer_pkg::PIN_IRQ0]); // RULE6
  assign en1 = timer_control_q[timer_pkg::ONE_RUN_BIT] && // RULE15
               (!timer_mode_select_q[timer_pkg::ONE_GATE_BIT] || pins.level[timer_pkg::PIN_IRQ1]); // RULE6

  // Counter select picks pin edges, otherwise every clock counts
  assign tick0 = en0 && (!timer_mode_select_q[timer_pkg::ZERO_CSEL_BIT] || pins.fall[timer_pkg::PIN_CNT0]); // RULE7
  assign tick1 = en1 && (!timer_mode_select_q[timer_pkg::ONE_CSEL_BIT] || pins.fall[timer_pkg::PIN_CNT1]); // RULE7
  assign tick2 = timer_two_control_q[timer_pkg::TWO_RUN_BIT] &&
                 (!timer_two_control_q[timer_pkg::TWO_CSEL_BIT] || pins.fall[timer_pkg::PIN_CNT2]); // RULE1
  // Split high byte counts clocks on the timer one run bit alone
  assign tick_split_hi = split0 && timer_control_q[timer_pkg::ONE_RUN_BIT]; // RULE12

  assign nxt0 = split0 ? {timer_zero_low_byte_q == 8'hff, timer_zero_high_byte_q, timer_zero_low_byte_q + 8'h01}
                       : count_step(mode0, timer_zero_high_byte_q, timer_zero_low_byte_q); // RULE12
  assign nxt1 = count_step(mode1, timer_one_high_byte_q, timer_one_low_byte_q);
  assign nxt2 = {1'b0, timer_two_high_byte_q, timer_two_low_byte_q} + 17'h00001;

  assign ovf0 = tick0 && nxt0[16]; // RULE17
  // Timer one overflow flag belongs to the split high byte while timer zero is split
  assign ovf1 = split0 ? (tick_split_hi && timer_zero_high_byte_q == 8'hff)
                       : (tick1 && mode1 != timer_pkg::MODE_SPLIT && nxt1[16]); // RULE12
  assign ovf2 = tick2 && nxt2[16];

  // Timer zero bytes; a software write wins over a count in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_zero_low_byte_q <= timer_pkg::REG_RESET;
    end else if (wr_tl0) begin
      timer_zero_low_byte_q <= sfr_wdata;
    end else if (tick0) begin
      timer_zero_low_byte_q <= nxt0[7:0]; // RULE2
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_zero_high_byte_q <= timer_pkg::REG_RESET;
    end else if (wr_th0) begin
      timer_zero_high_byte_q <= sfr_wdata;
    end else if (tick_split_hi) begin
      timer_zero_high_byte_q <= timer_zero_high_byte_q + 8'h01; // RULE12
    end else if (tick0 && !split0) begin
      timer_zero_high_byte_q <= nxt0[15:8];
    end
  end

  // Timer one bytes; mode 11 holds them
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_one_low_byte_q  <= timer_pkg::REG_RESET;
      timer_one_high_byte_q <= timer_pkg::REG_RESET;
    end else begin
      if (wr_tl1) begin
        timer_one_low_byte_q <= sfr_wdata;
      end else if (tick1) begin
        timer_one_low_byte_q <= nxt1[7:0]; // RULE11
      end
      if (wr_th1) begin
        timer_one_high_byte_q <= sfr_wdata;
      end else if (tick1) begin
        timer_one_high_byte_q <= nxt1[15:8];
      end
    end
  end

  // Timer two: 16-bit count reloaded from the reload pair on overflow
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_two_low_byte_q  <= timer_pkg::REG_RESET;
      timer_two_high_byte_q <= timer_pkg::REG_RESET;
    end else begin
      if (wr_tl2) begin
        timer_two_low_byte_q <= sfr_wdata;
      end else if (tick2) begin
        timer_two_low_byte_q <= ovf2 ? timer_two_reload_low_q : nxt2[7:0];
      end
      if (wr_th2) begin
        timer_two_high_byte_q <= sfr_wdata;
      end else if (tick2) begin
        timer_two_high_byte_q <= ovf2 ? timer_two_reload_high_q : nxt2[15:8];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_two_reload_low_q  <= timer_pkg::REG_RESET;
      timer_two_reload_high_q <= timer_pkg::REG_RESET;
    end else begin
      if (sfr_wr && sfr_addr == timer_pkg::ADDR_TIMER_TWO_RELOAD_LOW) begin
        timer_two_reload_low_q <= sfr_wdata;
      end
      if (sfr_wr && sfr_addr == timer_pkg::ADDR_TIMER_TWO_RELOAD_HIGH) begin
        timer_two_reload_high_q <= sfr_wdata;
      end
    end
  end

  // Mode register, byte writes only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_mode_select_q <= timer_pkg::REG_RESET; // RULE13
    end else if (sfr_wr && sfr_addr == timer_pkg::ADDR_TIMER_MODE_SELECT) begin
      timer_mode_select_q <= sfr_wdata;
    end
  end

  // Control register: software writes, vector clears, and overflow sets which win over both
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_control_q <= timer_pkg::REG_RESET;
    end else begin
      if (wr_ctrl) begin
        timer_control_q <= sfr_wdata;
      end else if (bit_ctrl) begin
        timer_control_q[bit_addr[2:0]] <= bit_wdata; // RULE14
      end
      if (vector_ack_zero) begin
        timer_control_q[timer_pkg::ZERO_FLAG_BIT] <= 1'b0; // RULE16
      end
      if (vector_ack_one) begin
        timer_control_q[timer_pkg::ONE_FLAG_BIT] <= 1'b0; // RULE16
      end
      if (ovf0) begin
        timer_control_q[timer_pkg::ZERO_FLAG_BIT] <= 1'b1; // RULE16
      end
      if (ovf1) begin
        timer_control_q[timer_pkg::ONE_FLAG_BIT] <= 1'b1; // RULE16
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_two_control_q <= timer_pkg::REG_RESET;
    end else begin
      if (wr_ctrl2) begin
        timer_two_control_q <= sfr_wdata;
      end else if (bit_ctrl2) begin
        timer_two_control_q[bit_addr[2:0]] <= bit_wdata; // RULE14
      end
      if (ovf2) begin
        timer_two_control_q[timer_pkg::TWO_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // Read data, unmapped addresses read zero
  always_comb begin
    case (sfr_addr)
      timer_pkg::ADDR_TIMER_CONTROL:         rdata_d = timer_control_q;
      timer_pkg::ADDR_TIMER_MODE_SELECT:     rdata_d = timer_mode_select_q;
      timer_pkg::ADDR_TIMER_ZERO_LOW_BYTE:   rdata_d = timer_zero_low_byte_q;
      timer_pkg::ADDR_TIMER_ONE_LOW_BYTE:    rdata_d = timer_one_low_byte_q;
      timer_pkg::ADDR_TIMER_ZERO_HIGH_BYTE:  rdata_d = timer_zero_high_byte_q;
      timer_pkg::ADDR_TIMER_ONE_HIGH_BYTE:   rdata_d = timer_one_high_byte_q;
      timer_pkg::ADDR_TIMER_TWO_CONTROL:     rdata_d = timer_two_control_q;
      timer_pkg::ADDR_TIMER_TWO_RELOAD_LOW:  rdata_d = timer_two_reload_low_q;
      timer_pkg::ADDR_TIMER_TWO_RELOAD_HIGH: rdata_d = timer_two_reload_high_q;
      timer_pkg::ADDR_TIMER_TWO_LOW_BYTE:    rdata_d = timer_two_low_byte_q;
      timer_pkg::ADDR_TIMER_TWO_HIGH_BYTE:   rdata_d = timer_two_high_byte_q;
      default:                               rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      rdata_q <= rdata_d;
    end
  end

  assign sfr_rdata                = rdata_q;
  assign timer_zero_overflow_flag = timer_control_q[timer_pkg::ZERO_FLAG_BIT];
  assign timer_one_overflow_flag  = timer_control_q[timer_pkg::ONE_FLAG_BIT];
  assign timer_two_overflow_flag  = timer_two_control_q[timer_pkg::TWO_FLAG_BIT];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_tf0_set_on_ovf: assert property (ovf0 |=> timer_zero_overflow_flag) // RULE16
    else $error("timer zero flag not set after overflow");
  a_tf0_vector_clr: assert property (vector_ack_zero && !ovf0 && !wr_ctrl && !bit_ctrl // RULE16
    |=> !timer_zero_overflow_flag)
    else $error("timer zero flag not cleared by vector");
  a_timer_clock_rate: assert property (mode0 == timer_pkg::MODE_CASCADE && en0 && !wr_tl0 // RULE2
    && !timer_mode_select_q[timer_pkg::ZERO_CSEL_BIT] |=> timer_zero_low_byte_q == $past(timer_zero_low_byte_q) + 8'h01)
    else $error("timer zero did not advance once per clock");
  a_count_needs_edge: assert property (timer_mode_select_q[timer_pkg::ZERO_CSEL_BIT] && !split0 // RULE3
    && !pins.fall[timer_pkg::PIN_CNT0] && !wr_tl0 |=> $stable(timer_zero_low_byte_q))
    else $error("counter advanced without a pin edge");
  a_gate_holds: assert property (timer_mode_select_q[timer_pkg::ZERO_GATE_BIT] // RULE6
    && !pins.level[timer_pkg::PIN_IRQ0] && !wr_tl0 && !wr_th0 && !split0
    |=> $stable({timer_zero_high_byte_q, timer_zero_low_byte_q}))
    else $error("gated timer zero counted with irq pin low");
  a_run_stop_holds: assert property (!timer_control_q[timer_pkg::ONE_RUN_BIT] && !wr_tl1 && !wr_th1 // RULE15
    |=> $stable({timer_one_high_byte_q, timer_one_low_byte_q}))
    else $error("timer one counted with run bit clear");
  a_reload_value: assert property (mode0 == timer_pkg::MODE_RELOAD && tick0 // RULE10
    && timer_zero_low_byte_q == 8'hff && !wr_tl0
    |=> timer_zero_low_byte_q == $past(timer_zero_high_byte_q) && timer_zero_overflow_flag)
    else $error("low byte not reloaded from high byte");
  a_mode3_one_stop: assert property (mode1 == timer_pkg::MODE_SPLIT && !wr_tl1 && !wr_th1 // RULE11
    |=> $stable({timer_one_high_byte_q, timer_one_low_byte_q}))
    else $error("timer one counted in mode 11");
  a_prescale_hold: assert property (mode0 == timer_pkg::MODE_PRESCALE // RULE8
    && timer_zero_low_byte_q[4:0] != 5'h1f && !wr_th0 |=> $stable(timer_zero_high_byte_q))
    else $error("high byte moved before prescaler wrapped");
  a_split_high_run: assert property (split0 && timer_control_q[timer_pkg::ONE_RUN_BIT] && !wr_th0 // RULE12
    |=> timer_zero_high_byte_q == $past(timer_zero_high_byte_q) + 8'h01)
    else $error("split high byte not driven by timer one run");
  a_edge_two_cycles: assert property (pins.fall[timer_pkg::PIN_CNT0] |=> !pins.fall[timer_pkg::PIN_CNT0]) // RULE4
    else $error("count edges closer than two cycles");
endmodule : timer_counters

// ===== test/pin_source.sv
// Model of the outside drivers of the count pins and the gate pins
`timescale 1ns/1ns
module pin_source (
  input  wire logic       clk,
  output logic      [4:0] pins
);
  // Lanes 0 to 2 are count pins, lanes 3 and 4 the gate pins
  initial begin
    pins = 5'h00;
  end

  // Each level is held three clocks, never less than one full clock
  task automatic falls(input int lane, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (3) @(posedge clk);
      pins[lane] <= 1'b1;
      repeat (3) @(posedge clk);
      pins[lane] <= 1'b0;
    end
  endtask : falls

  task automatic level(input int lane, input logic v);
    @(posedge clk);
    pins[lane] <= v;
  endtask : level
endmodule : pin_source

// ===== test/dual_mode_timer_counters_bench.sv
// Self-checking bench for the three timer/counters
`timescale 1ns/1ns
module dual_mode_timer_counters_bench;
  logic       clk;
  logic       arst_n;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic [7:0] sfr_wdata;
  logic       sfr_rd;
  logic [7:0] sfr_rdata;
  logic       bit_wr;
  logic [7:0] bit_addr;
  logic       bit_wdata;
  logic       ack0;
  logic       ack1;
  logic [4:0] pins;
  logic       flag0;
  logic       flag1;
  logic       flag2;
  int         error_cnt;
  int         n_compared;

  timer_counters timer_counters_i (.clk(clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .bit_wr(bit_wr), .bit_addr(bit_addr),
    .bit_wdata(bit_wdata), .vector_ack_zero(ack0), .vector_ack_one(ack1),
    .count_input_pin_zero(pins[0]), .count_input_pin_one(pins[1]), .count_input_pin_two(pins[2]),
    .external_irq_pin_zero(pins[3]), .external_irq_pin_one(pins[4]),
    .timer_zero_overflow_flag(flag0), .timer_one_overflow_flag(flag1), .timer_two_overflow_flag(flag2));
  pin_source pin_source_i (.clk(clk), .pins(pins));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask : cmp

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_wr    <= 1'b1;
    sfr_addr  <= a;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input string what, input logic [7:0] exp);
    @(posedge clk);
    sfr_rd   <= 1'b1;
    sfr_addr <= a;
    @(posedge clk);
    sfr_rd   <= 1'b0;
    #1;
    cmp(what, exp, sfr_rdata);
  endtask : rd

  task automatic bw(input logic [7:0] a, input logic v);
    @(posedge clk);
    bit_wr    <= 1'b1;
    bit_addr  <= a;
    bit_wdata <= v;
    @(posedge clk);
    bit_wr    <= 1'b0;
  endtask : bw

  // Run bit high for exactly n counting edges, n at least 2
  task automatic run_for(input logic [7:0] a, input int n);
    bw(a, 1'b1);
    repeat (n - 2) @(posedge clk);
    bw(a, 1'b0);
  endtask : run_for

  task automatic load(input logic [7:0] mode, input logic [7:0] lo, input logic [7:0] hi, input logic one);
    wr(timer_pkg::ADDR_TIMER_MODE_SELECT, mode);
    wr(one ? timer_pkg::ADDR_TIMER_ONE_LOW_BYTE : timer_pkg::ADDR_TIMER_ZERO_LOW_BYTE, lo);
    wr(one ? timer_pkg::ADDR_TIMER_ONE_HIGH_BYTE : timer_pkg::ADDR_TIMER_ZERO_HIGH_BYTE, hi);
  endtask : load

  task automatic reset_values;
    rd(timer_pkg::ADDR_TIMER_MODE_SELECT, "mode", 8'h00);
    rd(timer_pkg::ADDR_TIMER_CONTROL, "control", 8'h00);
    rd(8'h8e, "unmapped", 8'h00);
  endtask : reset_values

  task automatic wrap_and_ack;
    load(8'h01, 8'hff, 8'hff, 1'b0);
    run_for(8'h8c, 2);
    #1;
    cmp("flag zero", 8'h01, {7'h00, flag0});
    rd(timer_pkg::ADDR_TIMER_ZERO_LOW_BYTE, "low zero", 8'h01);
    rd(timer_pkg::ADDR_TIMER_ZERO_HIGH_BYTE, "high zero", 8'h00);
    rd(timer_pkg::ADDR_TIMER_CONTROL, "control", 8'h20);
    @(posedge clk);
    ack0 <= 1'b1;
    @(posedge clk);
    ack0 <= 1'b0;
    #1;
    cmp("flag zero", 8'h00, {7'h00, flag0});
  endtask : wrap_and_ack

  task automatic prescale;
    load(8'h00, 8'hfe, 8'h00, 1'b0);
    run_for(8'h8c, 3);
    rd(timer_pkg::ADDR_TIMER_ZERO_HIGH_BYTE, "high zero", 8'h01);
    rd(timer_pkg::ADDR_TIMER_ZERO_LOW_BYTE, "low zero", 8'he1);
  endtask : prescale

  task automatic reload;
    load(8'h22, 8'hfe, 8'h80, 1'b1);
    load(8'h22, 8'hfd, 8'h40, 1'b0);
    run_for(8'h8e, 5);
    run_for(8'h8c, 4);
    rd(timer_pkg::ADDR_TIMER_ONE_LOW_BYTE, "low one", 8'h83);
    rd(timer_pkg::ADDR_TIMER_ZERO_LOW_BYTE, "low zero", 8'h41);
    cmp("flag one", 8'h01, {7'h00, flag1});
    cmp("flag zero", 8'h01, {7'h00, flag0});
    @(posedge clk);
    ack1 <= 1'b1;
    @(posedge clk);
    ack1 <= 1'b0;
    #1;
    cmp("flag one", 8'h00, {7'h00, flag1});
  endtask : reload

  // Timer two counts clocks into its reload, then pin two edges
  task automatic timer_two;
    wr(timer_pkg::ADDR_TIMER_TWO_RELOAD_LOW, 8'h34);
    wr(timer_pkg::ADDR_TIMER_TWO_RELOAD_HIGH, 8'h12);
    wr(timer_pkg::ADDR_TIMER_TWO_LOW_BYTE, 8'hfe);
    wr(timer_pkg::ADDR_TIMER_TWO_HIGH_BYTE, 8'hff);
    run_for(8'hca, 3);
    rd(timer_pkg::ADDR_TIMER_TWO_LOW_BYTE, "low two", 8'h35);
    rd(timer_pkg::ADDR_TIMER_TWO_HIGH_BYTE, "high two", 8'h12);
    cmp("flag two", 8'h01, {7'h00, flag2});
    rd(timer_pkg::ADDR_TIMER_TWO_CONTROL, "control two", 8'h80);
    bw(8'hc9, 1'b1);
    bw(8'hca, 1'b1);
    pin_source_i.falls(2, 2);
    repeat (8) @(posedge clk);
    bw(8'hca, 1'b0);
    rd(timer_pkg::ADDR_TIMER_TWO_LOW_BYTE, "events two", 8'h37);
  endtask : timer_two

  task automatic split;
    load(8'h33, 8'h55, 8'h00, 1'b1);
    load(8'h33, 8'h20, 8'h10, 1'b0);
    run_for(8'h8e, 4);
    rd(timer_pkg::ADDR_TIMER_ONE_LOW_BYTE, "low one", 8'h55);
    rd(timer_pkg::ADDR_TIMER_ZERO_HIGH_BYTE, "high zero", 8'h14);
    rd(timer_pkg::ADDR_TIMER_ZERO_LOW_BYTE, "low zero", 8'h20);
  endtask : split

  task automatic gating;
    load(8'h09, 8'h00, 8'h00, 1'b0);
    run_for(8'h8c, 10);
    rd(timer_pkg::ADDR_TIMER_ZERO_LOW_BYTE, "gated low", 8'h00);
    pin_source_i.level(3, 1'b1);
    repeat (6) @(posedge clk);
    run_for(8'h8c, 10);
    rd(timer_pkg::ADDR_TIMER_ZERO_LOW_BYTE, "open low", 8'h0a);
  endtask : gating

  task automatic events;
    load(8'h05, 8'h00, 8'h00, 1'b0);
    bw(8'h8c, 1'b1);
    pin_source_i.falls(0, 3);
    repeat (8) @(posedge clk);
    bw(8'h8c, 1'b0);
    rd(timer_pkg::ADDR_TIMER_ZERO_LOW_BYTE, "events", 8'h03);
  endtask : events

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    {arst_n, sfr_addr, sfr_wr, sfr_wdata, sfr_rd, bit_wr, bit_addr, bit_wdata, ack0, ack1} = '0;
    error_cnt  = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    reset_values();
    wrap_and_ack();
    prescale();
    reload();
    split();
    gating();
    events();
    timer_two();
    wrap_up();
  end

  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
endmodule : dual_mode_timer_counters_bench
